// ==== pkg/sfr_filter_pkg.sv ====
// Constants and types shared by the register access filter
`default_nettype none
package sfr_filter_pkg;

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Cpu mode codes
  typedef enum logic [2:0]
  {
    MODE_BOOT   = 3'b000,
    MODE_TEST   = 3'b001,
    MODE_CL_OS  = 3'b010,
    MODE_SYSTEM = 3'b011,
    MODE_USER   = 3'b100
  } cpu_mode_e;

  // Register groups
  typedef enum logic [2:0]
  {
    GRP_NONE   = 3'b000,
    GRP_CPU    = 3'b001,
    GRP_MMU    = 3'b010,
    GRP_SYS    = 3'b011,
    GRP_FW     = 3'b100,
    GRP_CL_OS  = 3'b101,
    GRP_HW     = 3'b110
  } sfr_group_e;

  // Group address windows: base and mask of bits that must match
  localparam logic [7:0] CPU_BASE   = 8'h80;
  localparam logic [7:0] CPU_MASK   = 8'hf0;
  localparam logic [7:0] MMU_BASE   = 8'h90;
  localparam logic [7:0] MMU_MASK   = 8'hf8;
  localparam logic [7:0] SYS_BASE   = 8'h98;
  localparam logic [7:0] SYS_MASK   = 8'hf8;
  localparam logic [7:0] FW_BASE    = 8'ha0;
  localparam logic [7:0] FW_MASK    = 8'hf8;
  localparam logic [7:0] CL_OS_BASE = 8'ha8;
  localparam logic [7:0] CL_OS_MASK = 8'hf8;
  localparam logic [7:0] HW_BASE    = 8'hc0;
  localparam logic [7:0] HW_MASK    = 8'hc0;

  // Hardware component subgroup field inside the address
  localparam int HW_SUB_LSB = 3;
  localparam int HW_SUB_W   = 3;

  // Individual registers
  localparam logic [7:0] SEG_TABLE_LO_ADDR  = 8'h90;
  localparam logic [7:0] SEG_TABLE_HI_ADDR  = 8'h91;
  localparam logic [7:0] PROG_STATUS_H_ADDR = 8'h98;
  localparam logic [7:0] PROT_SYS_0_ADDR    = 8'h99;
  localparam logic [7:0] PROT_SYS_1_ADDR    = 8'h9a;
  localparam logic [7:0] PROT_SYS_2_ADDR    = 8'h9b;
  localparam logic [7:0] FW_CTRL_LOW_ADDR   = 8'ha0;
  localparam logic [7:0] FW_CTRL_HIGH_ADDR  = 8'ha1;
  localparam logic [7:0] CLK_SRC_SEL_ADDR   = 8'hc0;
  localparam logic [7:0] RAND_VALUE_ADDR    = 8'hc8;
  localparam logic [7:0] CIPHER_KEY_1_ADDR  = 8'hd0;
  localparam logic [7:0] CIPHER_KEY_2_ADDR  = 8'hd1;

  // Reset values
  localparam logic [7:0] SEG_TABLE_RST = 8'h00;
  localparam logic [7:0] FW_CTRL_RST   = 8'h00;
  localparam logic [7:0] DENIED_RDATA  = 8'h00;

  // Address window match
  function automatic logic in_window(input logic [7:0] a,
                                     input logic [7:0] base,
                                     input logic [7:0] mask);
    in_window = ((a & mask) == (base & mask));
  endfunction : in_window

endpackage : sfr_filter_pkg
`default_nettype wire

// ==== pkg/sfr_decode_if.sv ====
// Decoded address attributes passed from decoder to filter
`timescale 1ns/10ps
`default_nettype none
interface sfr_decode_if;
  import sfr_filter_pkg::*;

  logic [7:0] addr;       // Register address under decode
  sfr_group_e group;      // Group of the address
  logic [2:0] hw_sub;     // Hardware component subgroup
  logic       is_psh;     // Program status high
  logic       is_clock_source_select;  // Clock source select
  logic       is_prot;    // One of the protected system registers
  logic       is_rng;     // Random number value
  logic       is_key;     // One of the cipher key registers
  logic       is_fw_lo;   // Firewall control low
  logic       is_fw_hi;   // Firewall control high
  logic       is_seg_lo;  // Segment table address low
  logic       is_seg_hi;  // Segment table address high

  modport decoder (input addr, output group, hw_sub, is_psh, is_clock_source_select,
                   is_prot, is_rng, is_key, is_fw_lo, is_fw_hi,
                   is_seg_lo, is_seg_hi);
  modport filter (output addr, input group, hw_sub, is_psh, is_clock_source_select,
                  is_prot, is_rng, is_key, is_fw_lo, is_fw_hi,
                  is_seg_lo, is_seg_hi);
endinterface : sfr_decode_if
`default_nettype wire

// ==== rtl/sfr_group_decode.sv ====
// Address decoder for register groups and special registers
`timescale 1ns/10ps
`default_nettype none
module sfr_group_decode
  import sfr_filter_pkg::*;
(
  sfr_decode_if.decoder dec  // Decode attributes
);

  // Group from address windows
  always_comb
  begin
    if (in_window(dec.addr, CPU_BASE, CPU_MASK))
      dec.group = GRP_CPU;
    else if (in_window(dec.addr, MMU_BASE, MMU_MASK))
      dec.group = GRP_MMU;
    else if (in_window(dec.addr, SYS_BASE, SYS_MASK))
      dec.group = GRP_SYS;
    else if (in_window(dec.addr, FW_BASE, FW_MASK))
      dec.group = GRP_FW;
    else if (in_window(dec.addr, CL_OS_BASE, CL_OS_MASK))
      dec.group = GRP_CL_OS;
    else if (in_window(dec.addr, HW_BASE, HW_MASK))
      dec.group = GRP_HW;
    else
      dec.group = GRP_NONE;
  end

  // Subgroup and single register matches
  assign dec.hw_sub    = dec.addr[HW_SUB_LSB +: HW_SUB_W];
  assign dec.is_psh    = (dec.addr == PROG_STATUS_H_ADDR);
  assign dec.is_clock_source_select = (dec.addr == CLK_SRC_SEL_ADDR);
  assign dec.is_prot   = (dec.addr == PROT_SYS_0_ADDR) ||
                         (dec.addr == PROT_SYS_1_ADDR) ||
                         (dec.addr == PROT_SYS_2_ADDR);
  assign dec.is_rng    = (dec.addr == RAND_VALUE_ADDR);
  assign dec.is_key    = (dec.addr == CIPHER_KEY_1_ADDR) ||
                         (dec.addr == CIPHER_KEY_2_ADDR);
  assign dec.is_fw_lo  = (dec.addr == FW_CTRL_LOW_ADDR);
  assign dec.is_fw_hi  = (dec.addr == FW_CTRL_HIGH_ADDR);
  assign dec.is_seg_lo = (dec.addr == SEG_TABLE_LO_ADDR);
  assign dec.is_seg_hi = (dec.addr == SEG_TABLE_HI_ADDR);

endmodule : sfr_group_decode
`default_nettype wire

// ==== rtl/sfr_access_mode_filter.sv ====
// Mode based access filter in front of the register space
// Operation
// - Boot mode grants all register groups but mmu, except the fixed exceptions.
// - Test mode grants all register groups but mmu, except the fixed exceptions.
// - Contactless mode reads firewall regs, reads and writes its own regs.
// - Contactless hardware register access follows the two firewall controls.
// - System mode grants mmu, system, firewall and hardware groups.
// - User hardware register access follows current code segment rights.
// - General cpu registers are accessible in every mode.
// - Program status high also readable in contactless and user modes.
// - Clock source select always readable in contactless mode.
// - Mmu segmentation registers refused outside system mode.
// - The three protected system registers never return contents.
// - Random number value is read only in every mode.
// - Both cipher key registers are never readable.
// - Refused reads return zero, refused writes are discarded.
// - Segment table address registers clear to zero on reset.
`timescale 1ns/10ps
`default_nettype none
module sfr_access_mode_filter
  import sfr_filter_pkg::*;
(
  input  wire logic        mclk,           // Cpu clock
  input  wire logic        rstn,           // Async reset, active low
  input  wire logic [2:0]  cpu_mode,       // Current cpu mode code
  input  wire logic        cpu_req,        // Access request strobe
  input  wire logic        cpu_we,         // 1 write, 0 read
  input  wire logic [7:0]  cpu_addr,       // Register address
  input  wire logic [7:0]  cpu_wdata,      // Write data
  input  wire logic [7:0]  seg_hw_rd,      // Segment read rights/subgroup
  input  wire logic [7:0]  seg_hw_wr,      // Segment write rights/subgroup
  input  wire logic [7:0]  reg_rdata,      // Read data from register space
  output logic             cpu_grant,      // Access granted this cycle
  output logic             cpu_denied,     // Access refused this cycle
  output logic [7:0]       cpu_rdata_q,    // Read data, cycle after read
  output logic             cpu_rvalid_q,   // Read data valid
  output logic             reg_rd_en,      // Forwarded read strobe
  output logic             reg_wr_en,      // Forwarded write strobe
  output logic [7:0]       reg_addr,       // Forwarded address
  output logic [7:0]       reg_wdata,      // Forwarded write data
  output logic [15:0]      seg_table_base, // Segment table address
  output logic [7:0]       fw_rd_rights,   // Firewall control low value
  output logic [7:0]       fw_wr_rights    // Firewall control high value
);

  // Internal registers
  logic [7:0] seg_table_lo_q;
  logic [7:0] seg_table_hi_q;
  logic [7:0] firewall_control_low_q;
  logic [7:0] firewall_control_high_q;

  // Decision terms
  cpu_mode_e  mode;
  logic       mode_ok;
  logic       rd_ok;
  logic       wr_ok;
  logic       rd_allow;
  logic       wr_allow;
  logic       internal;
  logic       is_read;
  logic       is_write;
  logic [7:0] internal_rdata;
  logic [7:0] rdata_d;

  // Exception and grant terms
  logic       rd_blocked;
  logic       wr_blocked;
  logic       rd_grant;
  logic       wr_grant;

  sfr_decode_if dec ();

  // Address decoder instance
  sfr_group_decode u_decode
  (
    .dec (dec.decoder)
  );

  // Pick the bit of a per-subgroup rights vector
  function automatic logic sub_bit(input logic [7:0] rights,
                                   input logic [2:0] sub);
    sub_bit = rights[sub];
  endfunction : sub_bit

  // Boot and test modes reach every group but mmu and the fixed exceptions
  function automatic logic cfg_mode(input cpu_mode_e m);
    cfg_mode = (m == MODE_BOOT) || (m == MODE_TEST);
  endfunction : cfg_mode

  // Decode the incoming address in the access cycle
  assign dec.addr = cpu_addr;

  // Request kind, qualified by the strobe
  assign is_read  = cpu_req && !cpu_we;
  assign is_write = cpu_req && cpu_we;

  // Legal mode check, unknown codes are refused
  always_comb
  begin
    mode    = MODE_BOOT;
    mode_ok = 1'b0;
    unique case (cpu_mode)
      MODE_BOOT,
      MODE_TEST,
      MODE_CL_OS,
      MODE_SYSTEM,
      MODE_USER:
      begin
        mode    = cpu_mode_e'(cpu_mode);
        mode_ok = 1'b1;
      end
      default:
      begin
        mode    = MODE_BOOT;
        mode_ok = 1'b0;
      end
    endcase
  end

  // Group rights by mode, before fixed exceptions
  always_comb
  begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    unique case (dec.group)
      GRP_CPU:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      GRP_MMU:
      begin
        rd_ok = (mode == MODE_SYSTEM);
        wr_ok = (mode == MODE_SYSTEM);
      end
      GRP_SYS:
      begin
        rd_ok = cfg_mode(mode) ||
                (mode == MODE_SYSTEM) ||
                (dec.is_psh && ((mode == MODE_CL_OS) ||
                                (mode == MODE_USER)));
        wr_ok = cfg_mode(mode) ||
                (mode == MODE_SYSTEM);
      end
      GRP_FW:
      begin
        rd_ok = cfg_mode(mode) ||
                (mode == MODE_SYSTEM) ||
                (mode == MODE_CL_OS);
        wr_ok = cfg_mode(mode) ||
                (mode == MODE_SYSTEM);
      end
      GRP_CL_OS:
      begin
        rd_ok = cfg_mode(mode) ||
                (mode == MODE_CL_OS);
        wr_ok = cfg_mode(mode) ||
                (mode == MODE_CL_OS);
      end
      GRP_HW:
      begin
        unique case (mode)
          MODE_BOOT,
          MODE_TEST,
          MODE_SYSTEM:
          begin
            rd_ok = 1'b1;
            wr_ok = 1'b1;
          end
          MODE_CL_OS:
          begin
            rd_ok = sub_bit(firewall_control_low_q, dec.hw_sub) ||
                    dec.is_clock_source_select;
            wr_ok = sub_bit(firewall_control_high_q, dec.hw_sub);
          end
          MODE_USER:
          begin
            rd_ok = sub_bit(seg_hw_rd, dec.hw_sub);
            wr_ok = sub_bit(seg_hw_wr, dec.hw_sub);
          end
        endcase
      end
      GRP_NONE:
      begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  // Fixed per-register exceptions
  assign rd_blocked = dec.is_prot ||
                      dec.is_key;
  assign wr_blocked = dec.is_rng;

  // Exceptions override the group rights, unknown modes refuse all
  assign rd_allow = mode_ok && rd_ok && !rd_blocked;
  assign wr_allow = mode_ok && wr_ok && !wr_blocked;

  // Granted reads and writes in the access cycle
  assign rd_grant = is_read && rd_allow;
  assign wr_grant = is_write && wr_allow;

  // Grant and refusal strobes for the cpu
  assign cpu_grant  = rd_grant || wr_grant;
  assign cpu_denied = cpu_req && !cpu_grant;

  // Registers held inside the filter are not forwarded
  assign internal = dec.is_fw_lo || dec.is_fw_hi ||
                    dec.is_seg_lo || dec.is_seg_hi;

  // Forwarded strobes only for granted external accesses
  assign reg_rd_en = rd_grant && !internal;
  assign reg_wr_en = wr_grant && !internal;

  // Address and data pass through, qualified by the strobes
  assign reg_addr  = cpu_addr;
  assign reg_wdata = cpu_wdata;

  // Segment table address low byte, restrictive zero on reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      seg_table_lo_q <= SEG_TABLE_RST;
    else if (wr_grant && dec.is_seg_lo)
      seg_table_lo_q <= cpu_wdata;
  end

  // Segment table address high byte, restrictive zero on reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      seg_table_hi_q <= SEG_TABLE_RST;
    else if (wr_grant && dec.is_seg_hi)
      seg_table_hi_q <= cpu_wdata;
  end

  // Firewall read rights, closed on reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      firewall_control_low_q <= FW_CTRL_RST;
    else if (wr_grant && dec.is_fw_lo)
      firewall_control_low_q <= cpu_wdata;
  end

  // Firewall write rights, closed on reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      firewall_control_high_q <= FW_CTRL_RST;
    else if (wr_grant && dec.is_fw_hi)
      firewall_control_high_q <= cpu_wdata;
  end

  // Internal read mux
  always_comb
  begin
    internal_rdata = DENIED_RDATA;
    if (dec.is_fw_lo)
      internal_rdata = firewall_control_low_q;
    else if (dec.is_fw_hi)
      internal_rdata = firewall_control_high_q;
    else if (dec.is_seg_lo)
      internal_rdata = seg_table_lo_q;
    else if (dec.is_seg_hi)
      internal_rdata = seg_table_hi_q;
  end

  // Refused reads return zero instead of contents
  always_comb
  begin
    rdata_d = DENIED_RDATA;
    if (rd_allow)
      rdata_d = internal ? internal_rdata : reg_rdata;
  end

  // Read valid pulse, one cycle after every read
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cpu_rvalid_q <= 1'b0;
    else
      cpu_rvalid_q <= is_read;
  end

  // Read data register, held until the next read
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cpu_rdata_q <= DENIED_RDATA;
    else if (is_read)
      cpu_rdata_q <= rdata_d;
  end

  // Configuration values for the mmu and firewall logic
  assign seg_table_base = {seg_table_hi_q, seg_table_lo_q};
  assign fw_rd_rights   = firewall_control_low_q;
  assign fw_wr_rights   = firewall_control_high_q;

endmodule : sfr_access_mode_filter
`default_nettype wire

// ==== dv/sfr_filter_checker.sv ====
// Port level assertions for the register access filter
`timescale 1ns/10ps
`default_nettype none
module sfr_filter_checker
  import sfr_filter_pkg::*;
(
  input wire logic        mclk,           // Cpu clock
  input wire logic        rstn,           // Async reset, active low
  input wire logic [2:0]  cpu_mode,       // Cpu mode
  input wire logic        cpu_req,        // Request
  input wire logic        cpu_we,         // Write enable
  input wire logic [7:0]  cpu_addr,       // Address
  input wire logic        cpu_grant,      // Grant
  input wire logic        cpu_denied,     // Denied
  input wire logic [7:0]  cpu_rdata_q,    // Read data
  input wire logic        cpu_rvalid_q,   // Read valid
  input wire logic        reg_rd_en,      // Read strobe
  input wire logic        reg_wr_en,      // Write strobe
  input wire logic [15:0] seg_table_base, // Segment table address
  input wire logic [7:0]  fw_rd_rights,   // Firewall low
  input wire logic [7:0]  fw_wr_rights    // Firewall high
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Read and write request shapes
  sequence rd_s;
    cpu_req && !cpu_we;
  endsequence
  sequence wr_s;
    cpu_req && cpu_we;
  endsequence

  denied_flag_a: assert property (
    cpu_denied == (cpu_req && !cpu_grant))
    else $error("denied flag not the inverse of grant");
  idle_quiet_a: assert property (
    !cpu_req |-> !cpu_grant && !cpu_denied && !reg_rd_en && !reg_wr_en)
    else $error("grant or strobe without a request");
  read_valid_a: assert property (rd_s |=> cpu_rvalid_q)
    else $error("read valid missing one cycle after read");
  refused_zero_a: assert property (
    rd_s ##0 cpu_denied |=> cpu_rdata_q == 8'h00)
    else $error("refused read returned data");
  no_strobe_a: assert property (
    cpu_denied |-> !reg_rd_en && !reg_wr_en)
    else $error("strobe forwarded for refused access");
  mmu_mode_a: assert property (
    cpu_req && cpu_addr[7:3] == 5'h12 && cpu_mode != MODE_SYSTEM
    |-> cpu_denied)
    else $error("segment register reached outside system mode");
  prot_read_a: assert property (
    rd_s ##0 (cpu_addr inside {8'h99, 8'h9a, 8'h9b})
    |-> !cpu_grant ##1 cpu_rdata_q == 8'h00)
    else $error("protected register read granted");
  key_read_a: assert property (
    rd_s ##0 (cpu_addr inside {8'hd0, 8'hd1})
    |-> !cpu_grant ##1 cpu_rdata_q == 8'h00)
    else $error("cipher key read granted");
  rng_write_a: assert property (
    wr_s ##0 cpu_addr == 8'hc8 |-> !reg_wr_en && !cpu_grant)
    else $error("random value write forwarded");
  cpu_group_a: assert property (
    cpu_req && cpu_addr[7:4] == 4'h8 && cpu_mode <= 3'b100 |-> cpu_grant)
    else $error("general cpu register refused");
  seg_hold_a: assert property (
    !(cpu_req && cpu_we && cpu_grant && cpu_addr[7:1] == 7'h48)
    |=> $stable(seg_table_base))
    else $error("segment table address changed without granted write");
  fw_hold_a: assert property (
    !(cpu_req && cpu_we && cpu_grant && cpu_addr[7:1] == 7'h50)
    |=> $stable(fw_rd_rights) && $stable(fw_wr_rights))
    else $error("firewall controls changed without granted write");
  reset_clear_a: assert property (disable iff (1'b0)
    !rstn |-> seg_table_base == 16'h0000 && fw_rd_rights == 8'h00 &&
    fw_wr_rights == 8'h00)
    else $error("segment table address not cleared in reset");
endmodule : sfr_filter_checker

bind sfr_access_mode_filter sfr_filter_checker i_chk (.mclk, .rstn,
  .cpu_mode, .cpu_req, .cpu_we, .cpu_addr, .cpu_grant, .cpu_denied,
  .cpu_rdata_q, .cpu_rvalid_q, .reg_rd_en, .reg_wr_en, .seg_table_base,
  .fw_rd_rights, .fw_wr_rights);
`default_nettype wire

// ==== dv/sfr_space_model.sv ====
// Register space model answering forwarded accesses
`timescale 1ns/10ps
`default_nettype none
module sfr_space_model
(
  input  wire logic       mclk,      // Cpu clock
  input  wire logic       rstn,      // Async reset, active low
  input  wire logic       reg_rd_en, // Read strobe
  input  wire logic       reg_wr_en, // Write strobe
  input  wire logic [7:0] reg_addr,  // Address
  input  wire logic [7:0] reg_wdata, // Write data
  output logic      [7:0] reg_rdata  // Read data
);
  logic [7:0] mem_q [256];

  // Preset pattern on reset, store forwarded writes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      for (int i = 0; i < 256; i++)
        mem_q[i] <= 8'(i) ^ 8'h5a;
    else if (reg_wr_en)
      mem_q[reg_addr] <= reg_wdata;
  end

  // Without a read strobe the bus shows inverted contents
  assign reg_rdata = reg_rd_en ? mem_q[reg_addr] : ~mem_q[reg_addr];
endmodule : sfr_space_model
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the register access filter
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sfr_filter_pkg::*;

  localparam logic [2:0] bt = MODE_BOOT;
  localparam logic [2:0] ts = MODE_TEST;
  localparam logic [2:0] cl = MODE_CL_OS;
  localparam logic [2:0] sy = MODE_SYSTEM;
  localparam logic [2:0] us = MODE_USER;

  logic        mclk = 1'b0;
  logic        rstn = 1'b1;
  logic [2:0]  cpu_mode = 3'b000;
  logic        cpu_req = 1'b0;
  logic        cpu_we = 1'b0;
  logic [7:0]  cpu_addr = 8'h00;
  logic [7:0]  cpu_wdata = 8'h00;
  logic [7:0]  seg_hw_rd = 8'h00;
  logic [7:0]  seg_hw_wr = 8'h00;
  logic [7:0]  reg_rdata, cpu_rdata_q, reg_addr, reg_wdata;
  logic [7:0]  fw_rd_rights, fw_wr_rights;
  logic [15:0] seg_table_base;
  logic        cpu_grant, cpu_denied, cpu_rvalid_q, reg_rd_en, reg_wr_en;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  always #50 mclk = ~mclk;

  sfr_access_mode_filter i_dut (.mclk, .rstn, .cpu_mode, .cpu_req, .cpu_we,
    .cpu_addr, .cpu_wdata, .seg_hw_rd, .seg_hw_wr, .reg_rdata, .cpu_grant,
    .cpu_denied, .cpu_rdata_q, .cpu_rvalid_q, .reg_rd_en, .reg_wr_en,
    .reg_addr, .reg_wdata, .seg_table_base, .fw_rd_rights, .fw_wr_rights);

  sfr_space_model i_space (.mclk, .rstn, .reg_rd_en, .reg_wr_en, .reg_addr,
    .reg_wdata, .reg_rdata);

  // Compare one result
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One access: grant in its cycle, read data one cycle later
  task automatic acc(input logic [2:0] m, input int w, input logic [7:0] a,
                     input logic [7:0] d, input int g, input logic [7:0] r);
    @(negedge mclk);
    cpu_mode = m;
    cpu_req = 1'b1;
    cpu_we = w[0];
    cpu_addr = a;
    cpu_wdata = d;
    #10;
    chk("grant", {15'h0, g[0]}, {15'h0, cpu_grant});
    chk("denied", {15'h0, ~g[0]}, {15'h0, cpu_denied});
    @(posedge mclk);
    #1;
    chk("rvalid", {15'h0, ~w[0]}, {15'h0, cpu_rvalid_q});
    if (w == 0)
      chk("rdata", {8'h0, r}, {8'h0, cpu_rdata_q});
  endtask : acc

  // Verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Watchdog against a hung run
  initial
  begin
    #500000;
    n_mismatch++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    #1;
    rstn = 1'b0;
    repeat (16) @(posedge mclk);
    chk("seg_base_rst", 16'h0000, seg_table_base);
    chk("fw_rd_rst", 16'h0000, {8'h0, fw_rd_rights});
    @(negedge mclk);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++)
      acc(i < 5 ? 3'(i) : 3'b111, 0, 8'h80, 8'h00, i < 5,
          i < 5 ? 8'hda : 8'h00);
    acc(bt, 0, 8'ha8, 8'h00, 1, 8'hf2);
    acc(bt, 1, 8'hc8, 8'h77, 0, 8'h00);
    acc(bt, 0, 8'hc8, 8'h00, 1, 8'h92);
    acc(bt, 0, 8'h99, 8'h00, 0, 8'h00);
    acc(ts, 0, 8'h9b, 8'h00, 0, 8'h00);
    acc(bt, 0, 8'hd0, 8'h00, 0, 8'h00);
    acc(ts, 0, 8'hd1, 8'h00, 0, 8'h00);
    acc(bt, 0, 8'h90, 8'h00, 0, 8'h00);
    acc(ts, 1, 8'hc0, 8'h33, 1, 8'h00);
    acc(ts, 0, 8'hc0, 8'h00, 1, 8'h33);
    acc(sy, 1, 8'h90, 8'h12, 1, 8'h00);
    acc(sy, 1, 8'h91, 8'h34, 1, 8'h00);
    chk("seg_base", 16'h3412, seg_table_base);
    acc(sy, 1, 8'ha0, 8'h02, 1, 8'h00);
    acc(sy, 1, 8'ha1, 8'h08, 1, 8'h00);
    chk("fw_rights", 16'h0208, {fw_rd_rights, fw_wr_rights});
    acc(sy, 0, 8'h98, 8'h00, 1, 8'hc2);
    acc(sy, 0, 8'ha8, 8'h00, 0, 8'h00);
    acc(cl, 0, 8'ha0, 8'h00, 1, 8'h02);
    acc(cl, 1, 8'ha0, 8'hff, 0, 8'h00);
    chk("fw_rd_kept", 16'h0002, {8'h0, fw_rd_rights});
    acc(cl, 1, 8'ha8, 8'h44, 1, 8'h00);
    acc(cl, 0, 8'hc0, 8'h00, 1, 8'h33);
    acc(cl, 0, 8'hc8, 8'h00, 1, 8'h92);
    acc(cl, 0, 8'hd8, 8'h00, 0, 8'h00);
    acc(cl, 1, 8'hd8, 8'h55, 1, 8'h00);
    acc(cl, 1, 8'he0, 8'h55, 0, 8'h00);
    acc(cl, 0, 8'h98, 8'h00, 1, 8'hc2);
    acc(cl, 1, 8'h98, 8'h00, 0, 8'h00);
    acc(cl, 0, 8'h91, 8'h00, 0, 8'h00);
    @(negedge mclk);
    cpu_req = 1'b0;
    seg_hw_rd = 8'h10;
    seg_hw_wr = 8'h20;
    acc(us, 0, 8'he0, 8'h00, 1, 8'hba);
    acc(us, 0, 8'he8, 8'h00, 0, 8'h00);
    acc(us, 1, 8'he8, 8'h66, 1, 8'h00);
    acc(us, 1, 8'he0, 8'h66, 0, 8'h00);
    acc(us, 0, 8'h98, 8'h00, 1, 8'hc2);
    acc(us, 1, 8'h91, 8'h00, 0, 8'h00);
    acc(us, 0, 8'ha0, 8'h00, 0, 8'h00);
    chk("seg_base_kept", 16'h3412, seg_table_base);
    acc(bt, 0, 8'he8, 8'h00, 1, 8'h66);
    @(negedge mclk);
    cpu_req = 1'b0;
    rstn = 1'b0;
    #10;
    chk("seg_base_rst2", 16'h0000, seg_table_base);
    complete_run();
  end
endmodule : tb
`default_nettype wire
